// ### rtl/mwdt_params.svh
// Purpose: Timing counts and field positions of the word decoder.
// Assumes: A 40 MHz clock and a 1 Mbit/s Manchester line.
// Notes:   Cycle counts are derived from times in ns.
`ifndef MWDT_PARAMS_SVH
`define MWDT_PARAMS_SVH

`define MWDT_CLK_NS       25
`define MWDT_BIT_NS       1000
`define MWDT_SMP_A_NS     250
`define MWDT_SMP_B_NS     750
`define MWDT_SYNC_NS      1500
`define MWDT_SYNC_TOL_NS  250
`define MWDT_MID_TOL_NS   125
`define MWDT_BIT_CYC      (`MWDT_BIT_NS / `MWDT_CLK_NS)
`define MWDT_HALF_CYC     (`MWDT_BIT_CYC / 2)
`define MWDT_SMP_A_CYC    ((`MWDT_SMP_A_NS + `MWDT_CLK_NS - 1) / `MWDT_CLK_NS)
`define MWDT_SMP_B_CYC    ((`MWDT_SMP_B_NS + `MWDT_CLK_NS - 1) / `MWDT_CLK_NS)
`define MWDT_SYNC_CYC     (`MWDT_SYNC_NS / `MWDT_CLK_NS)
`define MWDT_SYNC_MIN_CYC ((`MWDT_SYNC_NS - `MWDT_SYNC_TOL_NS + `MWDT_CLK_NS - 1) / `MWDT_CLK_NS)
`define MWDT_SYNC_MAX_CYC ((`MWDT_SYNC_NS + `MWDT_SYNC_TOL_NS) / `MWDT_CLK_NS)
`define MWDT_MID_TOL_CYC  (`MWDT_MID_TOL_NS / `MWDT_CLK_NS)
`define MWDT_LAST_BIT     16
`define MWDT_FIFO_DEPTH   8
`define MWDT_RT_MSB       15
`define MWDT_RT_LSB       11
`define MWDT_TR_POS       10
`define MWDT_SA_MSB       9
`define MWDT_SA_LSB       5
`define MWDT_WC_MSB       4
`define MWDT_WC_LSB       0
`define MWDT_ME_POS       10
`define MWDT_INSTR_POS    9
`define MWDT_SRQ_POS      8
`define MWDT_BCR_POS      4
`define MWDT_BUSY_POS     3
`define MWDT_SSF_POS      2
`define MWDT_DBCA_POS     1
`define MWDT_TF_POS       0
`define MWDT_SA_MODE_LO   5'h00
`define MWDT_SA_MODE_HI   5'h1F
`define MWDT_WC_FULL      6'h20
`define MWDT_GAP_SAT      16'hFFFF

`endif

// ### rtl/mwdt_pkg.sv
// Purpose: Types shared by the word decoder, its checks and its bench.
// Assumes: Nothing beyond the parameter header.
// Notes:   Constants live in the header, types live here.
package mwdt_pkg;

  typedef enum logic [1:0] {MWDT_W_CMD, MWDT_W_DATA, MWDT_W_STATUS} mwdt_kind_t;
  typedef enum logic [1:0] {MWDT_S_CS, MWDT_S_DATA, MWDT_S_ALL} mwdt_sync_sel_t;
  typedef enum logic [1:0] {MWDT_T_ERROR, MWDT_T_CMD, MWDT_T_STATUS, MWDT_T_CMD_DATA} mwdt_tmode_t;
  typedef enum logic [1:0] {MWDT_HUNT, MWDT_SYNC2, MWDT_BITS} mwdt_state_t;

  typedef struct packed {
    logic sync_e;
    logic manch_e;
    logic parity_e;
    logic timeout_e;
  } mwdt_err_t;

  typedef struct packed {
    logic [15:0] min;
    logic [15:0] max;
    logic        inf;
  } mwdt_range_t;

  typedef struct packed {
    logic msg_err;
    logic srq;
    logic bcr;
    logic busy;
    logic ssf;
    logic dbca;
    logic tf;
  } mwdt_stat_t;

  typedef struct packed {
    mwdt_kind_t  kind;
    logic [15:0] payload;
    logic        par_bit;
    mwdt_err_t   err;
    logic [4:0]  rt_addr;
    logic        tr;
    logic [4:0]  subaddr;
    logic [4:0]  wc_mode;
    logic        mode_cmd;
    logic [5:0]  word_cnt;
    mwdt_stat_t  stat;
    logic [15:0] gap;
  } mwdt_word_t;

endpackage

// ### rtl/mwdt_fifo.sv
// Purpose: Keeps the word buffer's place in the file list.
// Assumes: The buffer module is defined beside the decoder.
// Notes:   All design logic stays in the decoder file.

// ### rtl/mwdt_decoder.sv
// Purpose: Manchester word decoder and trigger for a 1553 style line.
// Assumes: bus_rx_i is the thresholded line, asynchronous to ref_clk_i.
// Notes:   Decoded words are queued in an eight word buffer.
//
// Functional notes
// - One is high then low, zero reverse.
// - Each word opens with a non-Manchester sync.
// - Every word is command, data or status.
// - Ones over word without sync are odd.
// - Command splits into address, direction, subaddress, count, parity.
// - Subaddress 0 or 31 marks mode code.
// - One command moves at most 32 words.
// - At most 31 terminals, 30 subaddresses each.
// - Data word is sync, sixteen bits, parity.
// - Status message error bit set on error.
// - Status instrumentation bit zero, unlike commands.
// - Status flags decode active high, reserved ignored.
// - Sync trigger picks command/status, data or any.
// - Word trigger fires on configured word type.
// - Error trigger fires on individually enabled errors.
// - Sync error on bad sync shape.
// - Parity error when ones count is even.
// - Manchester error when cell lacks mid transition.
// - Timeout error when gap leaves its range.
// - Response time has min, max, unlimited option.
// - Message gap has min, max, unlimited option.
// - Four trigger modes: error, command, status, command-data.
`timescale 1ns/10ps
`include "mwdt_params.svh"

module mwdt_decoder (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rstn_i,
  input  wire logic                    bus_rx_i,
  input  wire logic                    invert_i,
  input  wire mwdt_pkg::mwdt_sync_sel_t sync_sel_i,
  input  wire mwdt_pkg::mwdt_kind_t     word_sel_i,
  input  wire mwdt_pkg::mwdt_tmode_t    trig_mode_i,
  input  wire mwdt_pkg::mwdt_err_t      err_en_i,
  input  wire mwdt_pkg::mwdt_range_t    resp_lim_i,
  input  wire mwdt_pkg::mwdt_range_t    inter_message_gap_lim_i,
  output logic                         sync_trig_o,
  output logic                         word_trig_o,
  output logic                         err_trig_o,
  output logic                         trig_o,
  output logic                         overflow_o,
  output logic                         word_valid_o,
  input  wire logic                    word_ready_i,
  output mwdt_pkg::mwdt_word_t         word_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Line capture.

  logic                  rx_meta;
  logic                  rx_sync;
  logic                  line;
  logic                  line_d;
  logic                  line_edge;
  mwdt_pkg::mwdt_state_t state;
  logic [6:0]            cnt;
  logic [6:0]            run_cnt;
  logic [4:0]            nbit;
  logic                  smp_a;
  logic                  smp_b;
  logic [16:0]           shreg;
  logic                  man_acc;
  logic                  cs_sync;
  logic                  done;
  logic                  sync_found;
  logic                  sync_abort;
  logic [15:0]           gap_cnt;
  logic [15:0]           gap_lat;
  logic                  have_prev;
  mwdt_pkg::mwdt_kind_t  prev_kind;
  mwdt_pkg::mwdt_word_t  wr;
  mwdt_pkg::mwdt_err_t   err_evt;
  logic                  fifo_ready;
  logic                  cmd_data_hit;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
      line    <= 1'b0;
      line_d  <= 1'b0;
    end else begin
      rx_meta <= bus_rx_i;
      rx_sync <= rx_meta;
      line    <= rx_sync ^ invert_i;
      line_d  <= line;
    end
  end

  assign line_edge = line ^ line_d;

  ////////////////////////////////////////////////////////////////////////////
  // Sync hunt and bit recovery.

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state      <= mwdt_pkg::MWDT_HUNT;
      cnt        <= '0;
      run_cnt    <= '0;
      nbit       <= '0;
      smp_a      <= 1'b0;
      smp_b      <= 1'b0;
      shreg      <= '0;
      man_acc    <= 1'b0;
      cs_sync    <= 1'b0;
      done       <= 1'b0;
      sync_found <= 1'b0;
      sync_abort <= 1'b0;
    end else begin
      done       <= 1'b0;
      sync_found <= 1'b0;
      sync_abort <= 1'b0;
      unique case (state)
        mwdt_pkg::MWDT_HUNT: begin
          if (line_edge) begin
            run_cnt <= '0;
            // A run of one and a half bits ending in an edge is a sync centre.
            if (run_cnt >= 7'(`MWDT_SYNC_MIN_CYC - 1) && run_cnt <= 7'(`MWDT_SYNC_MAX_CYC - 1)) begin
              state      <= mwdt_pkg::MWDT_SYNC2;
              cnt        <= '0;
              cs_sync    <= line_d;
              sync_found <= 1'b1;
            end
          end else if (run_cnt != 7'h7F) begin
            run_cnt <= run_cnt + 7'h01;
          end
        end
        mwdt_pkg::MWDT_SYNC2: begin
          if (line_edge && cnt < 7'(`MWDT_SYNC_MIN_CYC - 1)) begin
            state      <= mwdt_pkg::MWDT_HUNT;
            run_cnt    <= '0;
            sync_abort <= 1'b1;
          end else if (cnt == 7'(`MWDT_SYNC_CYC - 1)) begin
            state   <= mwdt_pkg::MWDT_BITS;
            cnt     <= '0;
            nbit    <= '0;
            man_acc <= 1'b0;
          end else begin
            cnt <= cnt + 7'h01;
          end
        end
        mwdt_pkg::MWDT_BITS: begin
          if (cnt == 7'(`MWDT_SMP_A_CYC - 1)) begin
            smp_a <= line;
          end
          if (cnt == 7'(`MWDT_SMP_B_CYC - 1)) begin
            smp_b <= line;
          end
          if (cnt == 7'(`MWDT_BIT_CYC - 1)) begin
            cnt     <= '0;
            shreg   <= {shreg[15:0], smp_a};
            man_acc <= man_acc | (smp_a == smp_b);
            if (nbit == 5'(`MWDT_LAST_BIT)) begin
              done    <= 1'b1;
              state   <= mwdt_pkg::MWDT_HUNT;
              run_cnt <= '0;
            end else begin
              nbit <= nbit + 5'h01;
            end
          end else if (line_edge && cnt >= 7'(`MWDT_HALF_CYC - `MWDT_MID_TOL_CYC)
                       && cnt <= 7'(`MWDT_HALF_CYC + `MWDT_MID_TOL_CYC)) begin
            // Realign on the mid-cell transition to follow transmitter drift.
            cnt <= 7'(`MWDT_HALF_CYC);
          end else begin
            cnt <= cnt + 7'h01;
          end
        end
        default: begin
          state <= mwdt_pkg::MWDT_HUNT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gap measurement between words.

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_cnt <= '0;
      gap_lat <= '0;
    end else begin
      if (done) begin
        gap_cnt <= '0;
      end else if (gap_cnt != `MWDT_GAP_SAT) begin
        gap_cnt <= gap_cnt + 16'h0001;
      end
      if (sync_found) begin
        gap_lat <= (gap_cnt > 16'(`MWDT_SYNC_CYC)) ? gap_cnt - 16'(`MWDT_SYNC_CYC) : 16'h0000;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      have_prev <= 1'b0;
      prev_kind <= mwdt_pkg::MWDT_W_DATA;
    end else if (done) begin
      have_prev <= 1'b1;
      prev_kind <= wr.kind;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word classification and field decode.

  function automatic logic in_range(input logic [15:0] v, input mwdt_pkg::mwdt_range_t r);
    return (v >= r.min) && (r.inf || v <= r.max);
  endfunction

  always_comb begin
    wr              = '0;
    wr.payload      = shreg[16:1];
    wr.par_bit      = shreg[0];
    wr.gap          = gap_lat;
    wr.err.manch_e  = man_acc;
    wr.err.parity_e = ~(^shreg);
    if (!cs_sync) begin
      wr.kind = mwdt_pkg::MWDT_W_DATA;
    end else if (have_prev && prev_kind != mwdt_pkg::MWDT_W_STATUS && !wr.payload[`MWDT_INSTR_POS]) begin
      wr.kind = mwdt_pkg::MWDT_W_STATUS;
    end else begin
      wr.kind = mwdt_pkg::MWDT_W_CMD;
    end
    wr.rt_addr  = wr.payload[`MWDT_RT_MSB:`MWDT_RT_LSB];
    if (wr.kind == mwdt_pkg::MWDT_W_CMD) begin
      wr.tr       = wr.payload[`MWDT_TR_POS];
      wr.subaddr  = wr.payload[`MWDT_SA_MSB:`MWDT_SA_LSB];
      wr.wc_mode  = wr.payload[`MWDT_WC_MSB:`MWDT_WC_LSB];
      wr.mode_cmd = (wr.subaddr == `MWDT_SA_MODE_LO) || (wr.subaddr == `MWDT_SA_MODE_HI);
      wr.word_cnt = (wr.wc_mode == 5'h00) ? `MWDT_WC_FULL : {1'b0, wr.wc_mode};
      if (wr.mode_cmd) begin
        wr.word_cnt = 6'h00;
      end
      wr.err.timeout_e = have_prev && !in_range(gap_lat, inter_message_gap_lim_i);
    end
    if (wr.kind == mwdt_pkg::MWDT_W_STATUS) begin
      wr.stat.msg_err  = wr.payload[`MWDT_ME_POS];
      wr.stat.srq      = wr.payload[`MWDT_SRQ_POS];
      wr.stat.bcr      = wr.payload[`MWDT_BCR_POS];
      wr.stat.busy     = wr.payload[`MWDT_BUSY_POS];
      wr.stat.ssf      = wr.payload[`MWDT_SSF_POS];
      wr.stat.dbca     = wr.payload[`MWDT_DBCA_POS];
      wr.stat.tf       = wr.payload[`MWDT_TF_POS];
      wr.err.timeout_e = !in_range(gap_lat, resp_lim_i);
    end
  end

  always_comb begin
    err_evt        = '0;
    err_evt.sync_e = sync_abort;
    if (done) begin
      err_evt = wr.err;
    end
  end

  assign cmd_data_hit = (wr.kind == mwdt_pkg::MWDT_W_DATA) && have_prev && (prev_kind == mwdt_pkg::MWDT_W_CMD);

  ////////////////////////////////////////////////////////////////////////////
  // Triggers.

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_trig_o <= 1'b0;
      word_trig_o <= 1'b0;
      err_trig_o  <= 1'b0;
      trig_o      <= 1'b0;
      overflow_o  <= 1'b0;
    end else begin
      sync_trig_o <= sync_found && ((sync_sel_i == mwdt_pkg::MWDT_S_ALL) ||
                     ((sync_sel_i == mwdt_pkg::MWDT_S_CS) == cs_sync));
      word_trig_o <= done && (wr.kind == word_sel_i);
      err_trig_o  <= |(err_evt & err_en_i);
      overflow_o  <= done && !fifo_ready;
      unique case (trig_mode_i)
        mwdt_pkg::MWDT_T_ERROR:    trig_o <= |(err_evt & err_en_i);
        mwdt_pkg::MWDT_T_CMD:      trig_o <= done && (wr.kind == mwdt_pkg::MWDT_W_CMD);
        mwdt_pkg::MWDT_T_STATUS:   trig_o <= done && (wr.kind == mwdt_pkg::MWDT_W_STATUS);
        mwdt_pkg::MWDT_T_CMD_DATA: trig_o <= done && cmd_data_hit;
        default:                   trig_o <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word buffer.

  mwdt_fifo #(
    .WIDTH ($bits(mwdt_pkg::mwdt_word_t)),
    .DEPTH (`MWDT_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (done),
    .in_ready_o  (fifo_ready),
    .in_data_i   (wr),
    .out_valid_o (word_valid_o),
    .out_ready_i (word_ready_i),
    .out_data_o  (word_o)
  );

endmodule

//////////////////////////////////////////////////////////////////////////////
// Word buffer: flip-flop storage, valid and ready on both sides.

module mwdt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // The count runs 0 to DEPTH, so full and empty need no spare slot.
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ### verification/mwdt_line_model.sv
// Purpose: Behavioural controller and terminal that drive the thresholded line.
// Assumes: Forty clocks per bit cell, twenty per half.
// Notes:   The line rests low between words, high while inv_i is set.
`timescale 1ns/10ps
module mwdt_line_model (
  input  wire logic ref_clk_i,
  input  wire logic inv_i,
  output logic      line_o
);
  logic lvl = 1'b0;
  assign line_o = lvl ^ inv_i;
  ////////////////////////////////////////
  task automatic hold(input logic v, input int n);
    lvl <= v;
    repeat (n) @(posedge ref_clk_i);
  endtask
  // A bad value of 1 drops one mid-cell edge, 2 cuts the sync short.
  task automatic send(input logic cs, input logic [16:0] bits, input int bad);
    hold(!cs, 10);
    hold(cs, 60);
    if (bad == 2) begin
      hold(!cs, 30);
      hold(cs, 30);
    end else begin
      hold(!cs, 60);
      for (int i = 16; i >= 0; i--) begin
        hold(bits[i], 20);
        hold((bad == 1 && i == 12) ? bits[i] : !bits[i], 20);
      end
    end
    hold(1'b0, 1);
  endtask
endmodule

// ### verification/mwdt_decoder_asserts.sv
// Purpose: Port checks of the word decoder.
// Assumes: Enables and limits change only between words.
// Notes:   Bound to the decoder after the module.
`timescale 1ns/10ps
module mwdt_decoder_asserts (
  input wire logic                     ref_clk_i,
  input wire logic                     rstn_i,
  input wire logic                     bus_rx_i,
  input wire logic                     invert_i,
  input wire mwdt_pkg::mwdt_sync_sel_t sync_sel_i,
  input wire mwdt_pkg::mwdt_kind_t     word_sel_i,
  input wire mwdt_pkg::mwdt_tmode_t    trig_mode_i,
  input wire mwdt_pkg::mwdt_err_t      err_en_i,
  input wire mwdt_pkg::mwdt_range_t    resp_lim_i,
  input wire mwdt_pkg::mwdt_range_t    inter_message_gap_lim_i,
  input wire logic                     sync_trig_o,
  input wire logic                     word_trig_o,
  input wire logic                     err_trig_o,
  input wire logic                     trig_o,
  input wire logic                     overflow_o,
  input wire logic                     word_valid_o,
  input wire logic                     word_ready_i,
  input wire mwdt_pkg::mwdt_word_t     word_o
);
  logic is_cmd;
  logic is_sts;
  assign is_cmd = word_valid_o && word_o.kind == mwdt_pkg::MWDT_W_CMD;
  assign is_sts = word_valid_o && word_o.kind == mwdt_pkg::MWDT_W_STATUS;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////
  kind_legal_a: assert property (word_valid_o |-> word_o.kind != 2'h3)
    else $error("Word kind out of range.");
  cmd_fields_a: assert property (is_cmd |-> {word_o.rt_addr, word_o.tr, word_o.subaddr,
    word_o.wc_mode} == word_o.payload) else $error("Command fields wrong.");
  mode_code_a: assert property (is_cmd |-> word_o.mode_cmd == (word_o.subaddr inside {5'h00, 5'h1F}))
    else $error("Mode flag wrong.");
  word_count_a: assert property (is_cmd |-> word_o.word_cnt == (word_o.mode_cmd ? 6'h00 :
    (word_o.wc_mode == 5'h00) ? 6'h20 : {1'b0, word_o.wc_mode})) else $error("Word count wrong.");
  status_instr_a: assert property (is_sts |-> !word_o.payload[9])
    else $error("Status with instrumentation bit.");
  status_flags_a: assert property (is_sts |-> word_o.stat == {word_o.payload[10],
    word_o.payload[8], word_o.payload[4:0]}) else $error("Status flags wrong.");
  parity_flag_a: assert property (word_valid_o |-> word_o.err.parity_e == ~^{word_o.payload,
    word_o.par_bit}) else $error("Parity flag wrong.");
  sync_kept_a: assert property (word_valid_o |-> !word_o.err.sync_e)
    else $error("Sync error stored in word.");
  err_enable_a: assert property (err_trig_o |-> |$past(err_en_i))
    else $error("Error trigger while disabled.");
  sync_pulse_a: assert property (sync_trig_o |=> !sync_trig_o)
    else $error("Sync trigger too long.");
  err_mode_a: assert property (trig_mode_i == mwdt_pkg::MWDT_T_ERROR && err_trig_o |-> trig_o)
    else $error("Error mode trigger missing.");
  head_hold_a: assert property (word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o))
    else $error("Buffer head changed while stalled.");
  word_trig_a: assert property (word_trig_o || overflow_o |-> word_valid_o)
    else $error("Trigger with empty buffer.");
endmodule

bind mwdt_decoder mwdt_decoder_asserts chk_u (.*);

// ### verification/tb.sv
// Purpose: Self-checking bench of the word decoder.
// Assumes: The line model sends whole words; the reader pops on demand.
// Notes:   Payloads come from a fixed seed.
`timescale 1ns/10ps
`include "mwdt_params.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
  logic                     ref_clk_i = 1'b0;
  logic                     rstn_i = 1'b0;
  logic                     invert_i = 1'b0;
  logic                     word_ready_i = 1'b0;
  logic                     bus_rx_i;
  logic                     sync_trig_o, word_trig_o, err_trig_o, trig_o, overflow_o, word_valid_o;
  mwdt_pkg::mwdt_sync_sel_t sync_sel_i = mwdt_pkg::MWDT_S_ALL;
  mwdt_pkg::mwdt_kind_t     word_sel_i = mwdt_pkg::MWDT_W_CMD;
  mwdt_pkg::mwdt_tmode_t    trig_mode_i = mwdt_pkg::MWDT_T_ERROR;
  mwdt_pkg::mwdt_err_t      err_en_i = 4'hF;
  mwdt_pkg::mwdt_range_t    resp_lim_i = {16'h0000, 16'hFFFF, 1'b1};
  mwdt_pkg::mwdt_range_t    inter_message_gap_lim_i = {16'h0000, 16'hFFFF, 1'b1};
  mwdt_pkg::mwdt_word_t     word_o;
  mwdt_pkg::mwdt_kind_t     prev = mwdt_pkg::MWDT_W_STATUS;
  int                       num_errors = 0, checks_done = 0, cyc = 0, seed;
  int                       n[5] = '{0, 0, 0, 0, 0};
  logic [27:0]              exp_q[$];
  always #12.5 ref_clk_i = ~ref_clk_i;
  mwdt_line_model line_u (.ref_clk_i(ref_clk_i), .inv_i(invert_i), .line_o(bus_rx_i));
  mwdt_decoder dut_u (.*);
  ////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    n <= '{n[0] + sync_trig_o, n[1] + word_trig_o, n[2] + err_trig_o, n[3] + trig_o, n[4] + overflow_o};
    if (cyc == 60000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic mwdt_pkg::mwdt_kind_t exp_kind(input logic cs, input logic [15:0] d);
    if (!cs) return mwdt_pkg::MWDT_W_DATA;
    if (prev != mwdt_pkg::MWDT_W_STATUS && !d[`MWDT_INSTR_POS]) return mwdt_pkg::MWDT_W_STATUS;
    return mwdt_pkg::MWDT_W_CMD;
  endfunction
  function automatic logic exp_trig(input mwdt_pkg::mwdt_kind_t k, input logic any, input logic nw);
    case (trig_mode_i)
      mwdt_pkg::MWDT_T_ERROR: return any;
      mwdt_pkg::MWDT_T_CMD: return nw && k == mwdt_pkg::MWDT_W_CMD;
      mwdt_pkg::MWDT_T_STATUS: return nw && k == mwdt_pkg::MWDT_W_STATUS;
      default: return nw && k == mwdt_pkg::MWDT_W_DATA && prev == mwdt_pkg::MWDT_W_CMD;
    endcase
  endfunction
  task automatic cfg(input int m, input int s, input int w, input logic [3:0] en);
    @(posedge ref_clk_i);
    trig_mode_i <= mwdt_pkg::mwdt_tmode_t'(m);
    sync_sel_i <= mwdt_pkg::mwdt_sync_sel_t'(s);
    word_sel_i <= mwdt_pkg::mwdt_kind_t'(w);
    err_en_i <= en;
  endtask
  task automatic word(input logic cs, input logic [15:0] d, input logic pe, input int bad, input logic to);
    mwdt_pkg::mwdt_kind_t k;
    logic [3:0]           er;
    logic [5:0]           wc;
    logic                 any, nw, full;
    int                   c0[5];
    #1;
    k = exp_kind(cs, d);
    er = {bad == 2, bad == 1, pe, to};
    any = |(er & err_en_i);
    nw = bad != 2;
    full = exp_q.size() == `MWDT_FIFO_DEPTH;
    wc = 6'h00;
    if (k == mwdt_pkg::MWDT_W_CMD && d[9:5] != `MWDT_SA_MODE_LO && d[9:5] != `MWDT_SA_MODE_HI) begin
      wc = (d[4:0] == 5'h00) ? `MWDT_WC_FULL : {1'b0, d[4:0]};
    end
    c0 = n;
    @(posedge ref_clk_i);
    line_u.send(cs, {d, ~^d ^ pe}, bad);
    repeat (25) @(posedge ref_clk_i);
    #1;
    `CHK("sync_trig", int'(sync_sel_i == mwdt_pkg::MWDT_S_ALL || (sync_sel_i == mwdt_pkg::MWDT_S_CS) == cs), n[0] - c0[0])
    `CHK("word_trig", int'(nw && k == word_sel_i), n[1] - c0[1])
    `CHK("err_trig", int'(any), n[2] - c0[2])
    `CHK("trig", int'(exp_trig(k, any, nw)), n[3] - c0[3])
    `CHK("overflow", int'(nw && full), n[4] - c0[4])
    if (nw && !full) exp_q.push_back({k, d, er, wc});
    if (nw) prev = k;
  endtask
  task automatic drain();
    logic [27:0] e;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      for (int i = 0; i < 50 && word_valid_o !== 1'b1; i++) begin
        @(posedge ref_clk_i);
        #1;
      end
      `CHK("word", e, {word_o.kind, word_o.payload, word_o.err, word_o.word_cnt})
      @(posedge ref_clk_i) word_ready_i <= 1'b1;
      @(posedge ref_clk_i) word_ready_i <= 1'b0;
      #1;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    seed = $urandom(26534);
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    for (int i = 0; i < 12; i++) begin
      cfg(i % 4, i % 3, (i / 4) % 3, 4'hF);
      word(1'($urandom), 16'($urandom), 1'($urandom), 0, 1'b0);
      drain();
    end
    cfg(1, 0, 2, 4'hF);
    word(1'b1, 16'h0A45, 1'b0, 0, 1'b0);
    word(1'b1, 16'h0D1F, 1'b0, 0, 1'b0);
    word(1'b1, 16'h1807, 1'b0, 0, 1'b0);
    word(1'b1, 16'h0BE3, 1'b0, 0, 1'b0);
    word(1'b1, 16'h0A40, 1'b0, 0, 1'b0);
    cfg(3, 1, 1, 4'hF);
    repeat (2) word(1'b0, 16'($urandom), 1'b0, 0, 1'b0);
    cfg(0, 2, 1, 4'h0);
    word(1'b0, 16'h1234, 1'b1, 0, 1'b0);
    drain();
    cfg(0, 2, 1, 4'h2);
    word(1'b0, 16'h1234, 1'b1, 0, 1'b0);
    cfg(0, 2, 1, 4'h4);
    word(1'b0, 16'h1800, 1'b0, 1, 1'b0);
    cfg(0, 2, 1, 4'h8);
    word(1'b1, 16'h0A45, 1'b0, 2, 1'b0);
    @(posedge ref_clk_i) invert_i <= 1'b1;
    word(1'b1, 16'h0A45, 1'b0, 0, 1'b0);
    drain();
    @(posedge ref_clk_i) invert_i <= 1'b0;
    err_en_i <= 4'h1;
    inter_message_gap_lim_i <= {16'h2000, 16'h0000, 1'b1};
    word(1'b0, 16'h00FF, 1'b0, 0, 1'b0);
    word(1'b1, 16'h0A45, 1'b0, 0, 1'b1);
    @(posedge ref_clk_i) inter_message_gap_lim_i <= {16'h0000, 16'h0064, 1'b0};
    repeat (600) @(posedge ref_clk_i);
    word(1'b1, 16'h0A45, 1'b0, 0, 1'b1);
    @(posedge ref_clk_i) inter_message_gap_lim_i <= {16'h0000, 16'h0064, 1'b1};
    repeat (600) @(posedge ref_clk_i);
    word(1'b1, 16'h0A45, 1'b0, 0, 1'b0);
    @(posedge ref_clk_i) resp_lim_i <= {16'h0000, 16'h0064, 1'b0};
    repeat (600) @(posedge ref_clk_i);
    word(1'b1, 16'h0D1F, 1'b0, 0, 1'b1);
    drain();
    cfg(0, 2, 1, 4'hF);
    repeat (9) word(1'b0, 16'($urandom), 1'b0, 0, 1'b0);
    drain();
    `CHK("empty", 1'b0, word_valid_o)
    end_of_test();
  end
endmodule
